// ===== shared/torque_pkg.sv
// package: constants, register map and types of the torque command selector
package torque_pkg;

  localparam int CMD_W = 16;
  localparam int ADDR_W = 16;

  // register offsets
  localparam logic [15:0] OFS_MODE = 16'h0102;
  localparam logic [15:0] OFS_TAU = 16'h010E;
  localparam logic [15:0] OFS_PRESET1 = 16'h0118;
  localparam logic [15:0] OFS_PRESET2 = 16'h011A;
  localparam logic [15:0] OFS_PRESET3 = 16'h011C;
  localparam logic [15:0] OFS_SCALE = 16'h0152;
  localparam logic [15:0] OFS_SRC = 16'h0200;
  localparam logic [15:0] OFS_CMD = 16'h0202;
  localparam logic [15:0] OFS_OUT = 16'h0204;

  // mode register fields
  localparam int MODE_ZERO_BIT = 0;
  localparam int MODE_LIMIT_BIT = 1;

  // reset values
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [15:0] RST_TAU = 16'h0000;
  localparam logic [15:0] RST_PRESET = 16'h0000;
  localparam logic [15:0] RST_SCALE = 16'h0064;

  // value ranges; commands are in 0.1 % of rated torque
  localparam int ANALOG_MAX_MV = 10000;
  localparam int PRESET_MAX_PCT = 300;
  localparam int SCALE_MAX_PCT = 1000;
  localparam int TAU_MAX_MS = 1000;
  localparam int CMD_PER_PCT = 10;
  localparam int SCALE_DIV = 1000;
  localparam logic signed [15:0] FULL_SCALE_CMD = 16'sh2710;

  // timing of the control-loop update
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_NS = 50000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_MS = 1000000 / TICK_PERIOD_NS;
  localparam int FILT_FRAC = 24;
  localparam int FILT_GAIN_NUM = (2 ** FILT_FRAC) / TICKS_PER_MS;

  typedef enum logic [4:0] {
    SRC_ANALOG = 5'h01,
    SRC_ZERO = 5'h02,
    SRC_PRESET1 = 5'h04,
    SRC_PRESET2 = 5'h08,
    SRC_PRESET3 = 5'h10
  } src_e;

endpackage

// ===== rtl/torque_smoother.sv
// first-order low-pass smoothing stage with bypass
`timescale 1ns/1ps
`default_nettype none
module torque_smoother (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // control
  input wire logic tick_i,
  input wire logic [15:0] tau_ms_i,
  // data
  input wire logic signed [15:0] cmd_i,
  output logic signed [15:0] cmd_o
);

  logic signed [39:0] acc_reg;
  logic [23:0] gain_reg;
  logic signed [16:0] diff;
  logic signed [41:0] prod;
  logic signed [41:0] acc_sum;

  // divider result is registered; a new nonzero tau takes effect one cycle late, a change to zero bypasses at once
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      gain_reg <= 24'h000000;
    end else if (tau_ms_i == 16'h0000) begin
      gain_reg <= 24'h000000;
    end else begin
      gain_reg <= 24'(torque_pkg::FILT_GAIN_NUM / int'(tau_ms_i));
    end
  end

  always_comb begin
    diff = 17'(cmd_i) - 17'(cmd_o);
    prod = 42'(diff * $signed({1'b0, gain_reg}));
    acc_sum = 42'(acc_reg) + prod;
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_reg <= 40'sh0000000000;
      cmd_o <= 16'sh0000;
    end else if (tau_ms_i == 16'h0000) begin
      acc_reg <= {cmd_i, 24'h000000};
      cmd_o <= cmd_i;
    end else if (tick_i) begin
      acc_reg <= acc_sum[39:0];
      cmd_o <= acc_sum[39:24];
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  property p_bypass;
    tau_ms_i == 16'h0000 |=> cmd_o == $past(cmd_i);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass output differs");

  property p_hold_between_ticks;
    tau_ms_i != 16'h0000 && !tick_i |=> $stable(cmd_o);
  endproperty
  a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("filter moved off tick");

  property p_move_toward;
    tau_ms_i != 16'h0000 && tick_i && cmd_o < cmd_i |=> cmd_o >= $past(cmd_o) && cmd_o <= $past(cmd_i);
  endproperty
  a_move_toward: assert property (p_move_toward) else $error("filter overshoot");

  c_filter_active: cover property (tau_ms_i != 16'h0000 && tick_i && cmd_o != cmd_i);

endmodule
`default_nettype wire

// ===== rtl/torque_cmd_select.sv
// torque command source selection, scaling and smoothing
//
// Function
// - select inputs 00 in analog submode: command is the scaled +-10 V input.
// - select inputs 00 in zero-torque submode: command is forced to zero.
// - select code 01, 10, 11 picks preset one, two, three, each +-300 %.
// - a preset value becomes active only when a select input changes.
// - source follows both select inputs and the configured zero/analog submode.
// - select input off reads as 0, on reads as 1.
// - in position or speed mode the command becomes the torque limit.
// - command is low-pass smoothed with a 0 to 1000 ms time constant.
// - time constant zero bypasses the smoothing stage entirely.
// - current-loop gains are not reachable; only selection, scaling, smoothing are.
// - analog command is voltage times max analog scale divided by ten, percent.
`timescale 1ns/1ps
`default_nettype none
module torque_cmd_select #(
  parameter int TICK_CYCLES = torque_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,

  // register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,

  // select pins and analog sample
  input wire logic torque_select_bit0_i,
  input wire logic torque_select_bit1_i,
  input wire logic signed [15:0] analog_mv_i,

  // command outputs
  output logic signed [15:0] torque_demand_o,
  output logic signed [15:0] torque_limit_o,
  output logic limit_mode_o,
  output logic [4:0] cmd_source_o
);

  logic [1:0] mode_reg;
  logic [15:0] tau_reg;
  logic signed [15:0] preset_reg [3];
  logic [15:0] scale_reg;

  logic [1:0] sel_meta_reg;
  logic [1:0] sel_sync_reg;
  logic [1:0] sel_prev_reg;
  logic sel_change;
  logic signed [15:0] active_preset_reg;

  torque_pkg::src_e src_reg;
  torque_pkg::src_e src_next;

  logic signed [15:0] ana_clamped;
  logic signed [31:0] ana_prod;
  logic signed [15:0] ana_scaled;
  logic signed [15:0] cmd_sel_next;
  logic signed [15:0] cmd_sel_reg;
  logic signed [15:0] smooth_out;

  logic [15:0] tick_cnt_reg;
  logic tick;

  function automatic logic signed [15:0] sat16(
    input logic signed [31:0] v,
    input int lim
  );
    if (v > lim) begin
      return 16'(lim);
    end else if (v < -lim) begin
      return 16'(-lim);
    end
    return v[15:0];
  endfunction

  // register writes; values are clamped to their documented ranges
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_reg <= torque_pkg::RST_MODE;
      tau_reg <= torque_pkg::RST_TAU;
      scale_reg <= torque_pkg::RST_SCALE;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        torque_pkg::OFS_MODE: begin
          mode_reg <= reg_wdata_i[1:0];
        end
        torque_pkg::OFS_TAU: begin
          tau_reg <= 16'(sat16(32'(reg_wdata_i), torque_pkg::TAU_MAX_MS));
        end
        torque_pkg::OFS_SCALE: begin
          scale_reg <= 16'(sat16(32'(reg_wdata_i), torque_pkg::SCALE_MAX_PCT));
        end
        default: begin
        end
      endcase
    end
  end

  // no gain registers of the current loop exist, so writes elsewhere are dropped
  generate
    for (genvar i = 0; i < 3; i++) begin : g_preset
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          preset_reg[i] <= torque_pkg::RST_PRESET;
        end else if (reg_wr_i && reg_addr_i == torque_pkg::OFS_PRESET1 + 16'(2 * i)) begin
          preset_reg[i] <= sat16(32'($signed(reg_wdata_i)), torque_pkg::PRESET_MAX_PCT);
        end
      end
    end
  endgenerate

  // select pins are asynchronous; two flops before use
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_meta_reg <= 2'h0;
      sel_sync_reg <= 2'h0;
    end else begin
      sel_meta_reg <= {torque_select_bit1_i, torque_select_bit0_i};
      sel_sync_reg <= sel_meta_reg;
    end
  end

  assign sel_change = sel_sync_reg != sel_prev_reg;

  // preset is captured on a select change only; later preset writes wait for the next change
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_prev_reg <= 2'h0;
      active_preset_reg <= 16'sh0000;
    end else begin
      sel_prev_reg <= sel_sync_reg;
      if (sel_change && sel_sync_reg != 2'h0) begin
        active_preset_reg <= preset_reg[sel_sync_reg - 2'h1];
      end
    end
  end

  // source uses the delayed code so that it lines up with the captured preset
  always_comb begin
    src_next = torque_pkg::SRC_ANALOG;
    unique case (sel_prev_reg)
      2'h0: begin
        if (mode_reg[torque_pkg::MODE_ZERO_BIT]) begin
          src_next = torque_pkg::SRC_ZERO;
        end else begin
          src_next = torque_pkg::SRC_ANALOG;
        end
      end
      2'h1: begin
        src_next = torque_pkg::SRC_PRESET1;
      end
      2'h2: begin
        src_next = torque_pkg::SRC_PRESET2;
      end
      2'h3: begin
        src_next = torque_pkg::SRC_PRESET3;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      src_reg <= torque_pkg::SRC_ANALOG;
    end else begin
      src_reg <= src_next;
    end
  end

  // analog scaling: mV times percent over 1000 gives 0.1 % units
  always_comb begin
    ana_clamped = sat16(32'(analog_mv_i), torque_pkg::ANALOG_MAX_MV);
    ana_prod = 32'(ana_clamped) * $signed({16'h0000, scale_reg});
    ana_scaled = 16'(ana_prod / torque_pkg::SCALE_DIV);
  end

  always_comb begin
    cmd_sel_next = 16'sh0000;
    unique case (src_reg)
      torque_pkg::SRC_ANALOG: begin
        cmd_sel_next = ana_scaled;
      end
      torque_pkg::SRC_ZERO: begin
        cmd_sel_next = 16'sh0000;
      end
      torque_pkg::SRC_PRESET1,
      torque_pkg::SRC_PRESET2,
      torque_pkg::SRC_PRESET3: begin
        cmd_sel_next = 16'(active_preset_reg * torque_pkg::CMD_PER_PCT);
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cmd_sel_reg <= 16'sh0000;
    end else begin
      cmd_sel_reg <= cmd_sel_next;
    end
  end

  // control-loop tick; shorten TICK_CYCLES in simulation
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt_reg <= 16'h0000;
    end else if (tick) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  assign tick = tick_cnt_reg == 16'(TICK_CYCLES - 1);

  torque_smoother u_smooth (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .tick_i(tick),
    .tau_ms_i(tau_reg),
    .cmd_i(cmd_sel_reg),
    .cmd_o(smooth_out)
  );

  // limit mode: the demand comes from the outer loop, this block bounds it
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      torque_demand_o <= 16'sh0000;
      torque_limit_o <= torque_pkg::FULL_SCALE_CMD;
      limit_mode_o <= 1'b0;
      cmd_source_o <= torque_pkg::SRC_ANALOG;
    end else begin
      limit_mode_o <= mode_reg[torque_pkg::MODE_LIMIT_BIT];
      cmd_source_o <= src_reg;
      if (mode_reg[torque_pkg::MODE_LIMIT_BIT]) begin
        torque_demand_o <= 16'sh0000;
        torque_limit_o <= smooth_out;
      end else begin
        torque_demand_o <= smooth_out;
        torque_limit_o <= torque_pkg::FULL_SCALE_CMD;
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        torque_pkg::OFS_MODE: begin
          reg_rdata_o <= {14'h0000, mode_reg};
        end
        torque_pkg::OFS_TAU: begin
          reg_rdata_o <= tau_reg;
        end
        torque_pkg::OFS_PRESET1: begin
          reg_rdata_o <= preset_reg[0];
        end
        torque_pkg::OFS_PRESET2: begin
          reg_rdata_o <= preset_reg[1];
        end
        torque_pkg::OFS_PRESET3: begin
          reg_rdata_o <= preset_reg[2];
        end
        torque_pkg::OFS_SCALE: begin
          reg_rdata_o <= scale_reg;
        end
        torque_pkg::OFS_SRC: begin
          reg_rdata_o <= {11'h000, src_reg};
        end
        torque_pkg::OFS_CMD: begin
          reg_rdata_o <= cmd_sel_reg;
        end
        torque_pkg::OFS_OUT: begin
          reg_rdata_o <= smooth_out;
        end
        default: begin
          reg_rdata_o <= 16'h0000;
        end
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  property p_analog;
    src_reg == torque_pkg::SRC_ANALOG |=> cmd_sel_reg == $past(ana_scaled);
  endproperty
  a_analog: assert property (p_analog) else $error("analog command not taken");

  property p_scale;
    src_reg == torque_pkg::SRC_ANALOG && ana_clamped == 16'sh2710 && scale_reg == 16'h0064
      |=> cmd_sel_reg == 16'sh03E8;
  endproperty
  a_scale: assert property (p_scale) else $error("analog scaling wrong");

  property p_zero;
    sel_prev_reg == 2'h0 && mode_reg[torque_pkg::MODE_ZERO_BIT]
      |=> src_reg == torque_pkg::SRC_ZERO ##1 cmd_sel_reg == 16'sh0000;
  endproperty
  a_zero: assert property (p_zero) else $error("zero submode not zero");

  property p_preset2;
    sel_prev_reg == 2'h2 |=> src_reg == torque_pkg::SRC_PRESET2
      ##1 cmd_sel_reg == 16'($past(active_preset_reg) * 10);
  endproperty
  a_preset2: assert property (p_preset2) else $error("preset two not used");

  property p_preset_hold;
    !sel_change |=> $stable(active_preset_reg);
  endproperty
  a_preset_hold: assert property (p_preset_hold) else $error("preset changed without select change");

  property p_submode;
    sel_prev_reg == 2'h0 && !mode_reg[torque_pkg::MODE_ZERO_BIT]
      |=> src_reg == torque_pkg::SRC_ANALOG;
  endproperty
  a_submode: assert property (p_submode) else $error("analog submode ignored");

  property p_pin_level;
    torque_select_bit1_i ##1 torque_select_bit1_i |=> sel_sync_reg[1];
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("select on not read as one");

  property p_limit;
    mode_reg[torque_pkg::MODE_LIMIT_BIT]
      |=> torque_demand_o == 16'sh0000 && torque_limit_o == $past(smooth_out);
  endproperty
  a_limit: assert property (p_limit) else $error("limit mode output wrong");

  property p_unmapped;
    reg_rd_i && reg_addr_i == 16'h0230 |=> reg_rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  c_analog: cover property (src_reg == torque_pkg::SRC_ANALOG && ana_scaled != 16'sh0000);
  c_zero: cover property (src_reg == torque_pkg::SRC_ZERO);
  c_preset3: cover property (sel_change ##2 src_reg == torque_pkg::SRC_PRESET3);
  c_limit: cover property (limit_mode_o && torque_limit_o != torque_pkg::FULL_SCALE_CMD);

endmodule
`default_nettype wire

// ===== verif/select_driver.sv
// far-side model: controller contacts and analog source feeding the selector
`timescale 1ns/1ps
`default_nettype none
module select_driver (
  // clock
  input wire logic mclk_i,
  // commands from the bench
  input wire logic contact0_on_i,
  input wire logic contact1_on_i,
  input wire logic signed [15:0] volt_mv_i,
  // pins toward the selector
  output logic torque_select_bit0_o,
  output logic torque_select_bit1_o,
  output logic signed [15:0] analog_mv_o
);
  // single driver per pin; the selector is still in reset when the first edge sets them
  // contacts only move right after an edge; an open contact reads 0, a closed one 1
  always @(posedge mclk_i) begin
    torque_select_bit0_o <= contact0_on_i;
    torque_select_bit1_o <= contact1_on_i;
    analog_mv_o <= volt_mv_i;
  end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the torque command selector
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int TICKS = 20;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] reg_addr_i = 16'h0000;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic con0 = 1'b0;
  logic con1 = 1'b0;
  logic signed [15:0] volt = 16'sh0000;
  logic sel0;
  logic sel1;
  logic signed [15:0] mv;
  logic signed [15:0] torque_demand_o;
  logic signed [15:0] torque_limit_o;
  logic limit_mode_o;
  logic [4:0] cmd_source_o;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  int m_mode = 0;
  int m_scale = 100;
  int m_code = 0;
  int m_mv = 0;
  int m_act = 0;
  int m_pre[3] = '{0, 0, 0};
  int d;
  int k;

  always #2.5 mclk_i = ~mclk_i;

  select_driver far (.mclk_i(mclk_i), .contact0_on_i(con0), .contact1_on_i(con1), .volt_mv_i(volt),
    .torque_select_bit0_o(sel0), .torque_select_bit1_o(sel1), .analog_mv_o(mv));

  torque_cmd_select #(.TICK_CYCLES(TICKS)) dut (.mclk_i(mclk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .torque_select_bit0_i(sel0), .torque_select_bit1_i(sel1),
    .analog_mv_i(mv), .torque_demand_o(torque_demand_o), .torque_limit_o(torque_limit_o),
    .limit_mode_o(limit_mode_o), .cmd_source_o(cmd_source_o));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard sized well above the longest filter settle
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] expv);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    // read data stand one cycle only; look just after the edge that launched them
    #1;
    check(reg_rdata_o, expv);
  endtask

  // selected command from the rules: analog scaled, zero, or latched preset
  function automatic int exp_cmd();
    int v;
    if (m_code != 0) return m_act * 10;
    if (m_mode[0]) return 0;
    v = (m_mv > 10000) ? 10000 : (m_mv < -10000) ? -10000 : m_mv;
    return v * m_scale / 1000;
  endfunction

  task automatic apply(input int code, input int v);
    @(posedge mclk_i);
    con0 <= code[0];
    con1 <= code[1];
    volt <= 16'(v);
    if (code != m_code && code != 0) m_act = m_pre[code - 1];
    m_code = code;
    m_mv = v;
    repeat (12) @(posedge mclk_i);
    #1;
  endtask

  task automatic check_out();
    int e;
    logic [15:0] s;
    e = exp_cmd();
    s = (m_mode[0] != 0) ? 16'h0002 : 16'h0001;
    if (m_code != 0) s = 16'(4 << (m_code - 1));
    check(torque_demand_o, m_mode[1] ? 16'h0000 : 16'(e));
    check(torque_limit_o, m_mode[1] ? 16'(e) : 16'h2710);
    check({15'h0000, limit_mode_o}, 16'(m_mode[1]));
    check({11'h000, cmd_source_o}, s);
    rd_chk(torque_pkg::OFS_CMD, 16'(e));
    rd_chk(torque_pkg::OFS_OUT, 16'(e));
  endtask

  initial begin
    void'($urandom(57211));
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    check_out();
    rd_chk(torque_pkg::OFS_MODE, 16'h0000);
    rd_chk(torque_pkg::OFS_TAU, 16'h0000);
    rd_chk(torque_pkg::OFS_PRESET1, 16'h0000);
    rd_chk(torque_pkg::OFS_SCALE, 16'h0064);
    rd_chk(16'h0300, 16'h0000);
    rd_chk(16'h0230, 16'h0000);
    // out-of-range writes clamp; read-only status ignores writes
    wr(torque_pkg::OFS_PRESET1, 16'h0190);
    rd_chk(torque_pkg::OFS_PRESET1, 16'h012C);
    wr(torque_pkg::OFS_PRESET2, 16'hFE70);
    rd_chk(torque_pkg::OFS_PRESET2, 16'hFED4);
    wr(torque_pkg::OFS_TAU, 16'h07D0);
    rd_chk(torque_pkg::OFS_TAU, 16'h03E8);
    wr(torque_pkg::OFS_TAU, 16'h0000);
    wr(torque_pkg::OFS_SRC, 16'h0010);
    rd_chk(torque_pkg::OFS_SRC, 16'h0001);
    // analog source with random scale and voltage, then over-range input
    for (k = 0; k < 6; k++) begin
      m_scale = ($urandom % 11) * 100;
      wr(torque_pkg::OFS_SCALE, 16'(m_scale));
      apply(0, (int'($urandom % 2001) - 1000) * 10);
      check_out();
    end
    m_scale = 100;
    wr(torque_pkg::OFS_SCALE, 16'h0064);
    apply(0, 12000);
    check_out();
    // zero-torque submode ignores the analog input
    m_mode = 1;
    wr(torque_pkg::OFS_MODE, 16'h0001);
    rd_chk(torque_pkg::OFS_MODE, 16'h0001);
    apply(0, 5000);
    check_out();
    // every preset code
    for (k = 0; k < 3; k++) begin
      m_pre[k] = int'($urandom % 601) - 300;
      wr(16'(torque_pkg::OFS_PRESET1 + 2 * k), 16'(m_pre[k]));
    end
    for (k = 1; k < 4; k++) begin
      apply(k, 0);
      check_out();
    end
    // a preset rewrite under a steady code waits for a select change
    m_pre[2] = -123;
    wr(torque_pkg::OFS_PRESET3, 16'(m_pre[2]));
    apply(3, 0);
    check_out();
    apply(0, 0);
    apply(3, 0);
    check_out();
    // position or speed mode: command becomes the limit
    m_mode = 2;
    wr(torque_pkg::OFS_MODE, 16'h0002);
    apply(1, 0);
    check_out();
    apply(0, -7000);
    check_out();
    // smoothing: step seen gradually after a few ticks, then settles near the target
    m_mode = 0;
    wr(torque_pkg::OFS_MODE, 16'h0000);
    apply(0, 0);
    wr(torque_pkg::OFS_TAU, 16'h0001);
    apply(0, 10000);
    rd_chk(torque_pkg::OFS_CMD, 16'h03E8);
    repeat (3 * TICKS) @(posedge mclk_i);
    #1;
    check((torque_demand_o > 0 && torque_demand_o < 1000) ? 16'h0001 : 16'h0000, 16'h0001);
    repeat (300 * TICKS) @(posedge mclk_i);
    #1;
    d = int'(torque_demand_o) - 1000;
    // truncation in the filter may leave a small offset below the target
    check((d >= -20 && d <= 1) ? 16'h0001 : 16'h0000, 16'h0001);
    wr(torque_pkg::OFS_TAU, 16'h0000);
    apply(0, -5000);
    check_out();
    report_and_stop();
  end
endmodule
`default_nettype wire
